// ===== hw/timer_bank_map.vh
// register offsets, field positions and reset values of the timer bank
`ifndef TIMER_BANK_MAP_VH
`define TIMER_BANK_MAP_VH
`define ADDR_INT_ENABLE   8'hA9
`define ADDR_INT_PRIORITY 8'hB9
`define ADDR_CTRL       8'hC8
`define ADDR_MODE       8'hC9
`define ADDR_RELOAD_LO  8'hCA
`define ADDR_RELOAD_HI  8'hCB
`define ADDR_COUNT_LO   8'hCC
`define ADDR_COUNT_HI   8'hCD
`define ADDR_BANK       8'hCE
`define ADDR_GLOBAL     8'hCF
`define BANK_RESET      3'h2
`define BANK_T2         3'h2
`define BANK_T3         3'h3
`define BANK_T4         3'h4
`define CTRL_OVF        7
`define CTRL_EXT        6
`define CTRL_RXBAUD     5
`define CTRL_TXBAUD     4
`define CTRL_EXTEN      3
`define CTRL_RUN        2
`define CTRL_CNTSEL     1
`define CTRL_CAPSEL     0
`define MODE_PRESC      7
`define MODE_CLKOUT     1
`define MODE_DOWN       0
`define INT_ENABLE_T4_BIT   7
`define INT_ENABLE_T3_BIT   6
`define INT_PRIORITY_T4_BIT 6
`define INT_PRIORITY_T3_BIT 5
`define PRESCALE_DIV    4'hC
`define COUNT_MAX       16'hFFFF
`endif

// ===== hw/pin_edge_sync.v
// three-stage pin synchroniser with falling edge detect
`timescale 1ns/10ps
`default_nettype none
module pin_edge_sync (
	input  wire clock,
	input  wire reset,
	input  wire pin_in,
	output reg  level,
	output wire fall
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	always @(posedge clock) begin
		if (reset) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			level  <= 1'b1;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				level <= s3_reg;
		end
	end
	// one pulse per accepted high-to-low change
	assign fall = level & (s2_reg == s3_reg) & ~s3_reg;
endmodule
`default_nettype wire

// ===== hw/timer_channel.v
// one 16-bit capture/reload/clock-out timer channel
`timescale 1ns/10ps
`default_nettype none
`include "timer_bank_map.vh"
module timer_channel #(
	parameter BAUD_OK = 0
) (
	input  wire        clock,
	input  wire        reset,
	input  wire        tick,
	input  wire        io_fall,
	input  wire        trig_level,
	input  wire        trig_fall,
	input  wire [7:0]  ctrl,
	input  wire [7:0]  mode,
	input  wire        wr_ctrl,
	input  wire        wr_rlo,
	input  wire        wr_rhi,
	input  wire        wr_clo,
	input  wire        wr_chi,
	input  wire [7:0]  wdata,
	output reg         ovf_flag,
	output reg         ext_flag,
	output reg  [15:0] count,
	output reg  [15:0] reload,
	output reg         clk_out,
	output wire        irq_src
);
	wire run     = ctrl[`CTRL_RUN];
	wire ext_en  = ctrl[`CTRL_EXTEN];
	wire cap     = ctrl[`CTRL_CAPSEL];
	wire cnt_sel = ctrl[`CTRL_CNTSEL];
	wire down_ok = mode[`MODE_DOWN];
	wire clk_en  = mode[`MODE_CLKOUT];
	wire baud    = (BAUD_OK != 0) && (ctrl[`CTRL_TXBAUD] || ctrl[`CTRL_RXBAUD]);
	wire clkmode = clk_en && !cnt_sel;
	wire updown  = down_ok && !cap && !baud && !clk_en;
	// counter mode counts pin falls, timer mode counts prescaled ticks
	wire step    = run && (cnt_sel ? io_fall : tick);
	wire go_down = updown && !trig_level;
	wire up_ovf  = step && !go_down && (count == `COUNT_MAX);
	wire dn_unf  = step && go_down && (count == reload);
	wire ovf     = up_ovf || dn_unf;
	wire trig    = trig_fall && ext_en && !updown;
	reg  [15:0] count_next;
	reg  [15:0] reload_next;
	reg         ovf_next;
	reg         ext_next;
	// output toggles every second overflow for a four-fold period
	reg         clk_half_reg;
	always @* begin
		count_next  = count;
		reload_next = reload;
		ovf_next    = ovf_flag;
		ext_next    = ext_flag;
		if (wr_ctrl) begin
			ovf_next = wdata[`CTRL_OVF];
			ext_next = wdata[`CTRL_EXT];
		end
		if (wr_rlo)
			reload_next[7:0] = wdata;
		if (wr_rhi)
			reload_next[15:8] = wdata;
		if (step) begin
			if (go_down)
				count_next = dn_unf ? `COUNT_MAX : count - 16'h0001;
			else if (up_ovf && !(cap && !baud && !clkmode))
				count_next = reload;
			else
				count_next = count + 16'h0001;
		end
		if (trig && cap && !baud && !clkmode)
			reload_next = count;
		else if (trig && !cap && !baud && !clkmode)
			count_next = reload;
		if (wr_clo)
			count_next[7:0] = wdata;
		if (wr_chi)
			count_next[15:8] = wdata;
		// hardware sets beat a clearing write, but an up/down overflow toggles the event flag
		if (ovf && !baud && !clkmode)
			ovf_next = 1'b1;
		if (trig)
			ext_next = 1'b1;
		if (updown && ovf)
			ext_next = ~ext_flag;
	end
	always @(posedge clock) begin
		if (reset) begin
			count    <= 16'h0000;
			reload   <= 16'h0000;
			ovf_flag <= 1'b0;
			ext_flag <= 1'b0;
			clk_out  <= 1'b0;
			clk_half_reg <= 1'b0;
		end else begin
			count    <= count_next;
			reload   <= reload_next;
			ovf_flag <= ovf_next;
			ext_flag <= ext_next;
			if (!clkmode) begin
				clk_out      <= 1'b0;
				clk_half_reg <= 1'b0;
			end else if (ovf) begin
				clk_half_reg <= ~clk_half_reg;
				if (clk_half_reg)
					clk_out <= ~clk_out;
			end
		end
	end
	assign irq_src = ovf_flag || (ext_flag && !updown);
endmodule
`default_nettype wire

// ===== hw/timer_bank.v
// shared register bank for timers 2, 3 and 4
// Notes on behaviour
// - timer 4 counts fsys/12 when prescale select is 0, fsys when 1
// - clock-out enable drives timer pin as clock; else pin is input
// - down-count allow 0 counts up; 1 lets trigger pin pick direction
// - enable register bit 7 gates timer 4 interrupt, resets to 0
// - priority register bit 6 selects timer 4 priority, resets to 0
// - capture select with run and no clock-out gives 16-bit capture
// - capture without trigger enable is plain timer; overflow sets flag
// - capture trigger fall copies count into reload and sets event flag
// - auto-reload up count overflows at FFFF, sets flag, reloads count
// - auto-reload trigger fall or overflow reloads; event flag set
// - down-count allow in auto-reload: pin sets direction, trigger ignored
// - pin high counts up, overflow sets flag and reloads
// - pin low counts down; match reload underflows, loads FFFF
// - in up/down mode event flag is seventeenth bit, no interrupt
// - only timer 2 has baud mode; overflow reloads, no interrupt
// - baud mode trigger fall sets event flag without reload
// - clock-out toggles pin every second overflow, no overflow interrupt
// - both flags share one vector, gated by global and timer enable (timer 2: global enable only)
// - flags set by hardware or software, cleared by software or reset; up/down overflow toggles event flag
// - bank pointer 010/011/100 picks timer 2/3/4, resets to 010
// - run off stops counting, trigger channel still active
// - timer advances only while run control is 1
// - counter select 0 timer mode, 1 counts pin events
`timescale 1ns/10ps
`default_nettype none
`include "timer_bank_map.vh"
module timer_bank #(
	parameter PRESCALE = `PRESCALE_DIV
) (
	input  wire       clock,
	input  wire       reset,
	input  wire [7:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr,
	input  wire       rd,
	output reg  [7:0] rdata,
	input  wire [2:0] timer_io_pin_in,
	output reg  [2:0] timer_io_pin_out,
	output reg  [2:0] timer_io_pin_oe,
	input  wire [2:0] ext_trigger_pin,
	output reg  [2:0] timer_irq,
	output reg  [2:0] timer_irq_high
);
	// ==========================================
	// registers
	reg  [7:0]  interrupt_enable_one_reg;
	reg  [7:0]  interrupt_priority_one_reg;
	reg  [2:0]  bank_reg;
	reg         global_irq_enable;
	reg  [7:0]  ctrl_reg [0:2];
	reg  [7:0]  mode_reg [0:2];
	reg  [3:0]  pre_reg;
	wire        pre_tick = (pre_reg == PRESCALE[3:0] - 4'h1);
	// bank pointer decode
	wire [2:0]  sel;
	assign sel[0] = (bank_reg == `BANK_T2);
	assign sel[1] = (bank_reg == `BANK_T3);
	assign sel[2] = (bank_reg == `BANK_T4);
	wire [2:0]  ovf_w;
	wire [2:0]  ext_w;
	wire [2:0]  clko_w;
	wire [2:0]  irqs_w;
	wire [47:0] count_w;
	wire [47:0] reload_w;
	wire [2:0]  en_bit;
	wire [2:0]  pri_bit;
	assign en_bit  = {interrupt_enable_one_reg[`INT_ENABLE_T4_BIT],
		interrupt_enable_one_reg[`INT_ENABLE_T3_BIT], global_irq_enable};
	assign pri_bit = {interrupt_priority_one_reg[`INT_PRIORITY_T4_BIT],
		interrupt_priority_one_reg[`INT_PRIORITY_T3_BIT], 1'b0};
	always @(posedge clock) begin
		if (reset) begin
			pre_reg <= 4'h0;
		end else if (pre_tick) begin
			pre_reg <= 4'h0;
		end else begin
			pre_reg <= pre_reg + 4'h1;
		end
	end
	// ==========================================
	// channels
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : ch
			wire io_level;
			wire io_fall;
			wire tr_level;
			wire tr_fall;
			wire tick = mode_reg[i][`MODE_PRESC] ? 1'b1 : pre_tick;
			pin_edge_sync io_sync (
				.clock  (clock),
				.reset  (reset),
				.pin_in (timer_io_pin_in[i]),
				.level  (io_level),
				.fall   (io_fall)
			);
			pin_edge_sync tr_sync (
				.clock  (clock),
				.reset  (reset),
				.pin_in (ext_trigger_pin[i]),
				.level  (tr_level),
				.fall   (tr_fall)
			);
			timer_channel #(
				.BAUD_OK (i == 0)
			) chan (
				.clock      (clock),
				.reset      (reset),
				.tick       (tick),
				.io_fall    (io_fall & ~mode_reg[i][`MODE_CLKOUT]),
				.trig_level (tr_level),
				.trig_fall  (tr_fall),
				.ctrl       (ctrl_reg[i]),
				.mode       (mode_reg[i]),
				.wr_ctrl    (wr && sel[i] && addr == `ADDR_CTRL),
				.wr_rlo     (wr && sel[i] && addr == `ADDR_RELOAD_LO),
				.wr_rhi     (wr && sel[i] && addr == `ADDR_RELOAD_HI),
				.wr_clo     (wr && sel[i] && addr == `ADDR_COUNT_LO),
				.wr_chi     (wr && sel[i] && addr == `ADDR_COUNT_HI),
				.wdata      (wdata),
				.ovf_flag   (ovf_w[i]),
				.ext_flag   (ext_w[i]),
				.count      (count_w[16*i+15:16*i]),
				.reload     (reload_w[16*i+15:16*i]),
				.clk_out    (clko_w[i]),
				.irq_src    (irqs_w[i])
			);
			always @(posedge clock) begin
				if (reset) begin
					ctrl_reg[i]         <= 8'h00;
					mode_reg[i]         <= 8'h00;
					timer_io_pin_out[i] <= 1'b0;
					timer_io_pin_oe[i]  <= 1'b0;
					timer_irq[i]        <= 1'b0;
					timer_irq_high[i]   <= 1'b0;
				end else begin
					if (wr && sel[i] && addr == `ADDR_CTRL)
						ctrl_reg[i] <= wdata;
					if (wr && sel[i] && addr == `ADDR_MODE)
						mode_reg[i] <= wdata;
					timer_io_pin_out[i] <= clko_w[i];
					timer_io_pin_oe[i]  <= mode_reg[i][`MODE_CLKOUT];
					// shared vector, needs global enable, and timer enable for timers 3 and 4
					timer_irq[i]      <= irqs_w[i] && global_irq_enable && en_bit[i];
					timer_irq_high[i] <= pri_bit[i];
				end
			end
		end
	endgenerate
	// ==========================================
	// register writes and reads
	always @(posedge clock) begin
		if (reset) begin
			interrupt_enable_one_reg   <= 8'h00;
			interrupt_priority_one_reg <= 8'h00;
			bank_reg                   <= `BANK_RESET;
			global_irq_enable          <= 1'b0;
		end else if (wr) begin
			case (addr)
				`ADDR_INT_ENABLE:   interrupt_enable_one_reg <= wdata;
				`ADDR_INT_PRIORITY: interrupt_priority_one_reg <= wdata;
				`ADDR_BANK:   bank_reg <= wdata[2:0];
				`ADDR_GLOBAL: global_irq_enable <= wdata[0];
				default: ;
			endcase
		end
	end
	reg [1:0] idx;
	always @* begin
		idx = 2'h0;
		if (sel[1])
			idx = 2'h1;
		if (sel[2])
			idx = 2'h2;
	end
	wire [15:0] cnt_sel_w = count_w[16*idx +: 16];
	wire [15:0] rld_sel_w = reload_w[16*idx +: 16];
	wire [7:0]  ctrl_view = {ovf_w[idx], ext_w[idx], ctrl_reg[idx][5:0]};
	wire        bank_ok   = |sel;
	always @(posedge clock) begin
		if (reset) begin
			rdata <= 8'h00;
		end else if (rd) begin
			case (addr)
				`ADDR_INT_ENABLE:   rdata <= interrupt_enable_one_reg;
				`ADDR_INT_PRIORITY: rdata <= interrupt_priority_one_reg;
				`ADDR_BANK:      rdata <= {5'h00, bank_reg};
				`ADDR_GLOBAL:    rdata <= {7'h00, global_irq_enable};
				`ADDR_CTRL:      rdata <= bank_ok ? ctrl_view : 8'h00;
				`ADDR_MODE:      rdata <= bank_ok ? {mode_reg[idx][7], 1'b0, mode_reg[idx][5:0]} : 8'h00;
				`ADDR_RELOAD_LO: rdata <= bank_ok ? rld_sel_w[7:0] : 8'h00;
				`ADDR_RELOAD_HI: rdata <= bank_ok ? rld_sel_w[15:8] : 8'h00;
				`ADDR_COUNT_LO:  rdata <= bank_ok ? cnt_sel_w[7:0] : 8'h00;
				`ADDR_COUNT_HI:  rdata <= bank_ok ? cnt_sel_w[15:8] : 8'h00;
				default:         rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// ===== verification/timer_bank_assertions.sv
// port-level checker for the timer bank, bound to the top module
`timescale 1ns/10ps
`default_nettype none
module timer_bank_checker #(
	parameter PRESCALE = 12
) (
	input wire logic       clock,
	input wire logic       reset,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic [2:0] timer_io_pin_oe,
	input wire logic [2:0] timer_irq,
	input wire logic [2:0] timer_irq_high
);
	// ==========================================
	// shadow of the pointer and interrupt bits
	logic [2:0] bk;
	logic       ie7;
	logic       ip6;
	logic       gen;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	always @(posedge clock) begin
		if (reset) begin
			bk <= 3'h2;
			ie7 <= 1'b0;
			ip6 <= 1'b0;
			gen <= 1'b0;
		end else if (wr) begin
			if (addr == 8'hCE) bk <= wdata[2:0];
			if (addr == 8'hA9) ie7 <= wdata[7];
			if (addr == 8'hB9) ip6 <= wdata[6];
			if (addr == 8'hCF) gen <= wdata[0];
		end
	end
	// ==========================================
	// assertions
	AST_BANK_READ: assert property (rd && addr == 8'hCE |=> rdata[2:0] == $past(bk))
		else $error("bank pointer read back wrong");
	AST_RESERVED_BANK: assert property (rd && addr >= 8'hC8 && addr <= 8'hCD && (bk < 3'h2 || bk > 3'h4)
		|=> rdata == 8'h00)
		else $error("reserved pointer read not zero");
	AST_IE1_READ: assert property (rd && addr == 8'hA9 |=> rdata[7] == $past(ie7))
		else $error("timer 4 enable bit read back wrong");
	AST_IP1_READ: assert property (rd && addr == 8'hB9 |=> rdata[6] == $past(ip6))
		else $error("timer 4 priority bit read back wrong");
	AST_T4_GATE: assert property (!ie7 ##1 !ie7 |-> !timer_irq[2])
		else $error("timer 4 request while disabled");
	AST_GLOBAL_GATE: assert property (!gen ##1 !gen |-> timer_irq == 3'h0)
		else $error("request while global enable off");
	AST_T4_PRIO: assert property (ip6 == $past(ip6) |-> timer_irq_high[2] == ip6)
		else $error("timer 4 priority output wrong");
	AST_OE_ON: assert property (wr && addr == 8'hC9 && bk == 3'h4 && wdata[1] |-> ##[1:2] timer_io_pin_oe[2])
		else $error("clock out enable not driven");
	AST_OE_OFF: assert property (wr && addr == 8'hC9 && bk == 3'h4 && !wdata[1] |-> ##[1:2] !timer_io_pin_oe[2])
		else $error("clock out enable not released");
endmodule
bind timer_bank timer_bank_checker #(.PRESCALE(PRESCALE)) chk_u (.clock(clock), .reset(reset), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .timer_io_pin_oe(timer_io_pin_oe),
	.timer_irq(timer_irq), .timer_irq_high(timer_irq_high));
`default_nettype wire

// ===== verification/timer_bank_bench.sv
// self-checking bench for the timer register bank
`timescale 1ns/10ps
`default_nettype none
module timer_bank_bench;
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  rdata;
	logic [2:0]  pin_in = 3'h7;
	logic [2:0]  pin_out;
	logic [2:0]  pin_oe;
	logic [2:0]  trig = 3'h7;
	logic [2:0]  irq;
	logic [2:0]  irq_high;
	logic        rd_q = 1'b0;
	logic [15:0] exp_q[$];
	logic [15:0] note;
	logic [7:0]  r0;
	logic        last;
	int          bad_count = 0;
	int          n_checks = 0;
	int          cycles = 0;
	int          edges;
	timer_bank #(.PRESCALE(12)) dut_u (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .timer_io_pin_in(pin_in), .timer_io_pin_out(pin_out),
		.timer_io_pin_oe(pin_oe), .ext_trigger_pin(trig), .timer_irq(irq), .timer_irq_high(irq_high));
	always #10 clock = ~clock;
	// ==========================================
	// bus tasks and comparison
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back({mask, exp & mask});
		@(posedge clock);
		rd <= 1'b0;
		@(posedge clock);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// read data stands only in the cycle after the strobe
	always @(posedge clock) begin
		rd_q <= rd;
		if (rd_q) begin
			note = exp_q.pop_front();
			check("rdata", rdata & note[15:8], note[7:0]);
		end
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 6000) begin
			bad_count++;
			finish_test;
		end
	end
	// ==========================================
	// scenarios
	initial begin
		void'($urandom(70));
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		rd_reg(8'hA9, 8'h00, 8'hFF);
		rd_reg(8'hB9, 8'h00, 8'hFF);
		rd_reg(8'hCE, 8'h02, 8'h07);
		rd_reg(8'hC8, 8'h00, 8'hCF);
		$display("test reset values done");
		r0 = 8'($urandom);
		for (int b = 2; b <= 4; b++) begin
			wr_reg(8'hCE, 8'(b));
			wr_reg(8'hCA, r0 ^ 8'(b));
		end
		for (int b = 2; b <= 4; b++) begin
			wr_reg(8'hCE, 8'(b));
			rd_reg(8'hCA, r0 ^ 8'(b), 8'hFF);
		end
		wr_reg(8'hCE, 8'h05);
		rd_reg(8'hCA, 8'h00, 8'hFF);
		$display("test bank routing done");
		wr_reg(8'hCE, 8'h04);
		wr_reg(8'hCA, 8'hF0);
		wr_reg(8'hCB, 8'hFF);
		wr_reg(8'hCC, 8'hF0);
		wr_reg(8'hCD, 8'hFF);
		wr_reg(8'hC9, 8'h80);
		wr_reg(8'hC8, 8'h04);
		rd_reg(8'hC8, 8'h00, 8'h80);
		repeat (30) @(posedge clock);
		rd_reg(8'hC8, 8'h80, 8'h80);
		rd_reg(8'hCD, 8'hFF, 8'hFF);
		wr_reg(8'hC8, 8'h00);
		wr_reg(8'hCC, 8'h55);
		repeat (20) @(posedge clock);
		rd_reg(8'hCC, 8'h55, 8'hFF);
		rd_reg(8'hC8, 8'h00, 8'h80);
		wr_reg(8'hC9, 8'h00);
		wr_reg(8'hCC, 8'hF0);
		wr_reg(8'hCD, 8'hFF);
		wr_reg(8'hC8, 8'h04);
		repeat (60) @(posedge clock);
		rd_reg(8'hC8, 8'h00, 8'h80);
		repeat (200) @(posedge clock);
		rd_reg(8'hC8, 8'h80, 8'h80);
		$display("test reload and prescale done");
		wr_reg(8'hC8, 8'h80);
		repeat (20) @(posedge clock);
		rd_reg(8'hC8, 8'h80, 8'hC4);
		wr_reg(8'hCF, 8'h01);
		wr_reg(8'hA9, 8'h80);
		repeat (4) @(posedge clock);
		check("irq", {5'h00, irq}, 8'h04);
		wr_reg(8'hA9, 8'h00);
		repeat (4) @(posedge clock);
		check("irq", {5'h00, irq}, 8'h00);
		wr_reg(8'hA9, 8'h80);
		wr_reg(8'hB9, 8'h40);
		repeat (4) @(posedge clock);
		check("irq_high", {7'h00, irq_high[2]}, 8'h01);
		wr_reg(8'hC8, 8'h00);
		repeat (4) @(posedge clock);
		check("irq", {5'h00, irq}, 8'h00);
		$display("test interrupt gating done");
		wr_reg(8'hCE, 8'h03);
		wr_reg(8'hCB, 8'h00);
		wr_reg(8'hCD, 8'h12);
		wr_reg(8'hCC, 8'h00);
		wr_reg(8'hC9, 8'h80);
		wr_reg(8'hC8, 8'h0D);
		trig <= 3'h5;
		repeat (10) @(posedge clock);
		rd_reg(8'hC8, 8'h40, 8'h40);
		rd_reg(8'hCB, 8'h12, 8'hFF);
		trig <= 3'h7;
		repeat (6) @(posedge clock);
		wr_reg(8'hC8, 8'h09);
		trig <= 3'h5;
		repeat (10) @(posedge clock);
		rd_reg(8'hC8, 8'h40, 8'h44);
		trig <= 3'h7;
		$display("test capture done");
		wr_reg(8'hCE, 8'h04);
		wr_reg(8'hCA, 8'hFC);
		wr_reg(8'hCC, 8'hFC);
		wr_reg(8'hC9, 8'h82);
		wr_reg(8'hC8, 8'h04);
		repeat (10) @(posedge clock);
		check("pin_oe", {7'h00, pin_oe[2]}, 8'h01);
		edges = 0;
		last = pin_out[2];
		repeat (160) begin
			@(posedge clock);
			if (pin_out[2] !== last) edges++;
			last = pin_out[2];
		end
		check("toggles", (edges >= 19 && edges <= 21) ? 8'h01 : 8'h00, 8'h01);
		rd_reg(8'hC8, 8'h00, 8'h80);
		wr_reg(8'hC9, 8'h80);
		repeat (4) @(posedge clock);
		check("pin_oe", {7'h00, pin_oe[2]}, 8'h00);
		$display("test clock out done");
		wr_reg(8'hCE, 8'h02);
		wr_reg(8'hCA, 8'hF0);
		wr_reg(8'hCB, 8'hFF);
		wr_reg(8'hCC, 8'hF0);
		wr_reg(8'hCD, 8'hFF);
		wr_reg(8'hC9, 8'h80);
		wr_reg(8'hC8, 8'h1C);
		trig <= 3'h6;
		repeat (40) @(posedge clock);
		rd_reg(8'hC8, 8'h40, 8'hC0);
		rd_reg(8'hCD, 8'hFF, 8'hFF);
		check("irq", {7'h00, irq[0]}, 8'h01);
		trig <= 3'h7;
		wr_reg(8'hC8, 8'h00);
		$display("test baud mode done");
		wr_reg(8'hCE, 8'h03);
		wr_reg(8'hCA, 8'h34);
		wr_reg(8'hCB, 8'h12);
		wr_reg(8'hCC, 8'hFE);
		wr_reg(8'hCD, 8'hFF);
		wr_reg(8'hC9, 8'h81);
		wr_reg(8'hC8, 8'h04);
		repeat (10) @(posedge clock);
		rd_reg(8'hC8, 8'hC0, 8'hC0);
		rd_reg(8'hCD, 8'h12, 8'hFF);
		wr_reg(8'hC8, 8'h0C);
		trig <= 3'h5;
		repeat (60) @(posedge clock);
		rd_reg(8'hC8, 8'hC0, 8'hC0);
		rd_reg(8'hCD, 8'hFF, 8'hFF);
		trig <= 3'h7;
		wr_reg(8'hC8, 8'h00);
		$display("test up down done");
		wr_reg(8'hC9, 8'h80);
		wr_reg(8'hCC, 8'h00);
		wr_reg(8'hCD, 8'h00);
		wr_reg(8'hC8, 8'h06);
		repeat (3) begin
			pin_in <= 3'h5;
			repeat (6) @(posedge clock);
			pin_in <= 3'h7;
			repeat (6) @(posedge clock);
		end
		rd_reg(8'hCC, 8'h03, 8'hFF);
		rd_reg(8'hCD, 8'h00, 8'hFF);
		$display("test counter mode done");
		finish_test;
	end
endmodule
`default_nettype wire
